/* rtl/facq_regs.svh */
// Timing constants and sizes for the frame acquisition sequencer
`ifndef FACQ_REGS_SVH
`define FACQ_REGS_SVH

// Clock period in picoseconds (125 MHz)
`define FACQ_CLK_PS          32'd8000

// Fixed global-shutter exposure start delays, in nanoseconds
`define FACQ_GS_DELAY_A_NS   32'd17620
`define FACQ_GS_DELAY_B_NS   32'd21480

// Rolling line reset mode delay bounds, in nanoseconds
`define FACQ_RS_MIN_NS       32'd190000
`define FACQ_RS_MAX_NS       32'd200000

// Overlap-dependent delay bounds, in nanoseconds
`define FACQ_OV_MIN_NS       32'd200
`define FACQ_OV_MAX_NS       32'd17200

// One microsecond in nanoseconds
`define FACQ_US_NS           32'd1000

// Frame buffer geometry
`define FACQ_DATA_W          16
`define FACQ_BUF_DEPTH       256
`define FACQ_PTR_W           8

`endif

/* rtl/facq_pkg.sv */
// Types shared by the frame acquisition sequencer
package facq_pkg;

  typedef enum logic [1:0] {
    FACQ_GS_A,
    FACQ_GS_B,
    FACQ_ROLLING,
    FACQ_OVERLAP
  } facq_delay_mode_t;

  typedef enum {
    FACQ_WAIT_TRIG,
    FACQ_START_DLY,
    FACQ_EXPOSE,
    FACQ_READOUT
  } facq_state_t;

endpackage

/* rtl/facq_sequencer.sv */
// Frame acquisition sequencer: trigger, exposure, readout, buffered send
`timescale 1ns/1ps
`default_nettype none
`include "facq_regs.svh"

// What this block does
// - Trigger rising edge in timed mode starts exposure after start delay.
// - Exposure done starts sensor readout into the frame buffer.
// - Transmission starts only once buffer holds enough to never underrun.
// - Global-shutter delay is a fixed per-configuration constant.
// - Rolling line reset delay varies with exposure time, 190 to 200 us.
// - Overlap variant: minimum delay when not overlapped, up to upper bound.
// - Total delay adds input response, debounce and trigger delay.
// - Transmission never finishes faster than the readout.
// - Readout time in microseconds is readable as an output.
// - Transmission start delay counts from readout start to send start.
// - Trigger while not waiting is ignored and flags overtrigger.
// - Trigger-wait high while waiting, low once trigger accepted.
module facq_sequencer (
  input  wire logic                        MCLK,
  input  wire logic                        ARST_N,
  input  wire logic                        EXT_FRAME_TRIGGER,
  input  wire facq_pkg::facq_delay_mode_t  DELAY_MODE,
  input  wire logic                        OVERLAP_EN,
  input  wire logic [23:0]                 EXPOSURE_CYC,
  input  wire logic [23:0]                 EXTRA_DELAY_CYC,
  input  wire logic [15:0]                 FRAME_WORDS,
  input  wire logic                        SENSOR_VALID,
  input  wire logic [`FACQ_DATA_W-1:0]     SENSOR_DATA,
  input  wire logic                        TX_READY,
  output logic                             TX_VALID,
  output logic [`FACQ_DATA_W-1:0]          TX_DATA,
  output logic                             TX_FIRST,
  output logic                             EXPOSING,
  output logic                             READING,
  output logic                             TRIGGER_WAIT,
  output logic                             OVERTRIGGER,
  output logic [15:0]                      READOUT_TIME_US,
  output logic [23:0]                      TX_START_DELAY
);

  // ==========================================================
  // Delay arithmetic
  // ==========================================================
  localparam logic [23:0] GS_A_CYC = 24'((`FACQ_GS_DELAY_A_NS * 32'd1000
                                    + `FACQ_CLK_PS - 32'd1) / `FACQ_CLK_PS);
  localparam logic [23:0] GS_B_CYC = 24'((`FACQ_GS_DELAY_B_NS * 32'd1000
                                    + `FACQ_CLK_PS - 32'd1) / `FACQ_CLK_PS);
  localparam logic [23:0] RS_MIN_CYC = 24'((`FACQ_RS_MIN_NS * 32'd1000
                                    + `FACQ_CLK_PS - 32'd1) / `FACQ_CLK_PS);
  localparam logic [23:0] RS_MAX_CYC = 24'((`FACQ_RS_MAX_NS * 32'd1000)
                                    / `FACQ_CLK_PS);
  localparam logic [23:0] OV_MIN_CYC = 24'((`FACQ_OV_MIN_NS * 32'd1000
                                    + `FACQ_CLK_PS - 32'd1) / `FACQ_CLK_PS);
  localparam logic [23:0] OV_MAX_CYC = 24'((`FACQ_OV_MAX_NS * 32'd1000)
                                    / `FACQ_CLK_PS);
  localparam logic [23:0] US_CYC     = 24'((`FACQ_US_NS * 32'd1000)
                                    / `FACQ_CLK_PS);

  // Clamp a value into a [lo, hi] window
  function automatic logic [23:0] clamp24(input logic [23:0] v,
                                          input logic [23:0] lo,
                                          input logic [23:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // Start delay chosen per configuration, extras added on top
  function automatic logic [23:0] start_delay(
      input facq_pkg::facq_delay_mode_t m, input logic ov,
      input logic [23:0] expo, input logic [23:0] extra);
    logic [23:0] base;
    base = GS_A_CYC;
    case (m)
      facq_pkg::FACQ_GS_A:    base = GS_A_CYC;
      facq_pkg::FACQ_GS_B:    base = GS_B_CYC;
      facq_pkg::FACQ_ROLLING: base = clamp24(RS_MIN_CYC + (expo >> 6),
                                             RS_MIN_CYC, RS_MAX_CYC);
      facq_pkg::FACQ_OVERLAP: base = ov ? clamp24(OV_MIN_CYC + expo,
                                             OV_MIN_CYC, OV_MAX_CYC)
                                        : OV_MIN_CYC;
      default:                base = GS_A_CYC;
    endcase
    return base + extra;
  endfunction

  // ==========================================================
  // Frame buffer
  // ==========================================================
  logic [`FACQ_DATA_W-1:0] buf_mem [`FACQ_BUF_DEPTH];
  logic [`FACQ_PTR_W-1:0]  wr_ptr;
  logic [`FACQ_PTR_W-1:0]  rd_ptr;
  logic [`FACQ_PTR_W:0]    fill;
  logic [`FACQ_PTR_W-1:0]  next_wr_ptr;
  logic [`FACQ_PTR_W-1:0]  next_rd_ptr;
  logic [`FACQ_PTR_W:0]    next_fill;

  // ==========================================================
  // Sequencer state
  // ==========================================================
  facq_pkg::facq_state_t state;
  facq_pkg::facq_state_t next_state;
  logic        trig_q;
  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic [15:0] rd_words;
  logic [15:0] next_rd_words;
  logic [15:0] tx_words;
  logic [15:0] next_tx_words;
  logic        sending;
  logic        next_sending;
  logic [23:0] us_div;
  logic [23:0] next_us_div;
  logic [15:0] ro_us;
  logic [15:0] next_ro_us;
  logic [23:0] tsd;
  logic [23:0] next_tsd;
  logic        tsd_run;
  logic        next_tsd_run;
  logic        next_overtrig;
  logic        trig_rise;
  logic        wr_en;
  logic        rd_en;
  logic        send_ok;

  assign trig_rise = EXT_FRAME_TRIGGER & ~trig_q;
  // A full buffer refuses further sensor words; writing one more would
  // overwrite a word that has not been sent yet
  assign wr_en     = (state == facq_pkg::FACQ_READOUT) && SENSOR_VALID
                     && (fill < 9'(`FACQ_BUF_DEPTH));
  // Hold back sending until the words still to come can arrive in time:
  // sensor fills one word a cycle, so half a buffer of margin is enough
  // when less than the whole frame is buffered.
  assign send_ok   = (fill >= 9'(`FACQ_BUF_DEPTH / 2))
                     || (rd_words == FRAME_WORDS && fill != 9'h000);
  // Pop a word only while the output stage is empty or being taken, and
  // never ahead of what the sensor has delivered
  assign rd_en     = (sending || send_ok) && fill != 9'h000
                     && (!TX_VALID || TX_READY)
                     && tx_words < rd_words;

  // Next-state logic for the sequencer and buffer
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_rd_words = rd_words;
    next_tx_words = tx_words;
    next_sending  = sending;
    next_us_div   = us_div;
    next_ro_us    = ro_us;
    next_tsd      = tsd;
    next_tsd_run  = tsd_run;
    next_overtrig = 1'b0;
    next_wr_ptr   = wr_en ? wr_ptr + 8'h01 : wr_ptr;
    next_rd_ptr   = rd_en ? rd_ptr + 8'h01 : rd_ptr;
    next_fill     = fill + {8'h00, wr_en} - {8'h00, rd_en};
    // Edges outside the wait state are dropped and flagged
    if (trig_rise && state != facq_pkg::FACQ_WAIT_TRIG) begin
      next_overtrig = 1'b1;
    end
    case (state)
      facq_pkg::FACQ_WAIT_TRIG: begin
        if (trig_rise) begin
          next_state = facq_pkg::FACQ_START_DLY;
          next_cnt   = start_delay(DELAY_MODE, OVERLAP_EN,
                                   EXPOSURE_CYC, EXTRA_DELAY_CYC);
        end
      end
      facq_pkg::FACQ_START_DLY: begin
        if (cnt <= 24'h000001) begin
          next_state = facq_pkg::FACQ_EXPOSE;
          next_cnt   = EXPOSURE_CYC;
        end else begin
          next_cnt = cnt - 24'h000001;
        end
      end
      facq_pkg::FACQ_EXPOSE: begin
        if (cnt <= 24'h000001) begin
          next_state    = facq_pkg::FACQ_READOUT;
          next_rd_words = 16'h0000;
          next_tx_words = 16'h0000;
          // Readout time restarts with the new frame
          next_ro_us    = 16'h0000;
          next_us_div   = 24'h000000;
          next_tsd      = 24'h000000;
          next_tsd_run  = 1'b1;
          next_sending  = 1'b0;
        end else begin
          next_cnt = cnt - 24'h000001;
        end
      end
      facq_pkg::FACQ_READOUT: begin
        // Readout time measured in microseconds
        // The count steps up as each new microsecond begins, so it is the
        // elapsed time rounded up; a short frame still reads one
        if (rd_words != FRAME_WORDS) begin
          if (us_div == 24'h000000) begin
            next_ro_us = ro_us + 16'h0001;
          end
          if (us_div == US_CYC - 24'h000001) begin
            next_us_div = 24'h000000;
          end else begin
            next_us_div = us_div + 24'h000001;
          end
        end
        if (wr_en && rd_words != FRAME_WORDS) begin
          next_rd_words = rd_words + 16'h0001;
        end
        if (tsd_run) begin
          next_tsd = tsd + 24'h000001;
        end
        if (rd_en) begin
          next_sending  = 1'b1;
          next_tsd_run  = 1'b0;
          next_tx_words = tx_words + 16'h0001;
        end
        // Frame ends once every word has been sent
        if (tx_words == FRAME_WORDS && rd_words == FRAME_WORDS
            && (!TX_VALID || TX_READY)) begin
          next_state   = facq_pkg::FACQ_WAIT_TRIG;
          next_sending = 1'b0;
        end
      end
      default: next_state = facq_pkg::FACQ_WAIT_TRIG;
    endcase
  end

  // Register the sequencer and output stage
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state           <= facq_pkg::FACQ_WAIT_TRIG;
      trig_q          <= 1'b0;
      cnt             <= 24'h000000;
      rd_words        <= 16'h0000;
      tx_words        <= 16'h0000;
      sending         <= 1'b0;
      us_div          <= 24'h000000;
      ro_us           <= 16'h0000;
      tsd             <= 24'h000000;
      tsd_run         <= 1'b0;
      wr_ptr          <= 8'h00;
      rd_ptr          <= 8'h00;
      fill            <= 9'h000;
      TX_VALID        <= 1'b0;
      TX_DATA         <= 16'h0000;
      TX_FIRST        <= 1'b0;
      EXPOSING        <= 1'b0;
      READING         <= 1'b0;
      TRIGGER_WAIT    <= 1'b0;
      OVERTRIGGER     <= 1'b0;
      READOUT_TIME_US <= 16'h0000;
      TX_START_DELAY  <= 24'h000000;
    end else begin
      state           <= next_state;
      trig_q          <= EXT_FRAME_TRIGGER;
      cnt             <= next_cnt;
      rd_words        <= next_rd_words;
      tx_words        <= next_tx_words;
      sending         <= next_sending;
      us_div          <= next_us_div;
      ro_us           <= next_ro_us;
      tsd             <= next_tsd;
      tsd_run         <= next_tsd_run;
      wr_ptr          <= next_wr_ptr;
      rd_ptr          <= next_rd_ptr;
      fill            <= next_fill;
      // Output stage holds its word until the host takes it
      if (rd_en) begin
        TX_VALID <= 1'b1;
        TX_DATA  <= buf_mem[rd_ptr];
        TX_FIRST <= (tx_words == 16'h0000);
      end else if (TX_READY) begin
        TX_VALID <= 1'b0;
        TX_FIRST <= 1'b0;
      end
      EXPOSING        <= (next_state == facq_pkg::FACQ_EXPOSE);
      READING         <= (next_state == facq_pkg::FACQ_READOUT)
                         && (next_rd_words != FRAME_WORDS);
      TRIGGER_WAIT    <= (next_state == facq_pkg::FACQ_WAIT_TRIG);
      OVERTRIGGER     <= next_overtrig;
      READOUT_TIME_US <= next_ro_us;
      // Counted up to the edge that raises TX_VALID, so the figure spans
      // the rise of READING to the rise of TX_VALID
      if (rd_en && !sending) begin
        TX_START_DELAY <= tsd + 24'h000001;
      end
    end
  end

  // Buffer array has no reset; contents are don't-care until written
  always_ff @(posedge MCLK) begin
    if (wr_en) begin
      buf_mem[wr_ptr] <= SENSOR_DATA;
    end
  end

endmodule

`default_nettype wire

/* bench/facq_seq_monitor.sv */
// Port checker for the frame acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
`include "facq_regs.svh"
module facq_seq_monitor (
  input wire logic                    MCLK,
  input wire logic                    ARST_N,
  input wire logic                    EXT_FRAME_TRIGGER,
  input wire logic [23:0]             EXPOSURE_CYC,
  input wire logic                    TX_READY,
  input wire logic                    TX_VALID,
  input wire logic [`FACQ_DATA_W-1:0] TX_DATA,
  input wire logic                    TX_FIRST,
  input wire logic                    EXPOSING,
  input wire logic                    READING,
  input wire logic                    TRIGGER_WAIT,
  input wire logic                    OVERTRIGGER
);
  // ==========================================
  // Exposure length tracking
  logic [23:0] exp_cnt;
  logic [23:0] exp_len;
  logic [23:0] next_exp_cnt;
  logic [23:0] next_exp_len;
  // Length is latched while idle, so a late change of the input is ignored
  always_comb begin
    next_exp_cnt = EXPOSING ? exp_cnt + 24'h1 : 24'h0;
    next_exp_len = EXPOSING ? exp_len : EXPOSURE_CYC;
  end
  // Registers only
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      exp_cnt <= 24'h0;
      exp_len <= 24'h0;
    end else begin
      exp_cnt <= next_exp_cnt;
      exp_len <= next_exp_len;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  sequence s_accept;
    TRIGGER_WAIT && $rose(EXT_FRAME_TRIGGER);
  endsequence
  sequence s_busy_edge;
    (EXPOSING || READING) && $rose(EXT_FRAME_TRIGGER);
  endsequence
  a_accept_leaves: assert property (s_accept |=> !TRIGGER_WAIT)
    else $error("wait stayed high after trigger");
  a_busy_ignored: assert property (s_busy_edge |=>
    OVERTRIGGER && !TRIGGER_WAIT)
    else $error("busy trigger not flagged");
  a_ot_cause: assert property (OVERTRIGGER |->
    $past(EXT_FRAME_TRIGGER) && !$past(EXT_FRAME_TRIGGER, 2))
    else $error("overtrigger without edge");
  a_ot_single: assert property (OVERTRIGGER |=> !OVERTRIGGER)
    else $error("overtrigger longer than a cycle");
  a_expose_read: assert property ($fell(EXPOSING) |->
    ##[0:2] READING)
    else $error("no readout after exposure");
  a_expose_len: assert property ($fell(EXPOSING) |->
    exp_cnt == exp_len)
    else $error("exposure length wrong");
  a_wait_idle: assert property (TRIGGER_WAIT |->
    !EXPOSING && !READING && !TX_VALID)
    else $error("busy while waiting");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA) && $stable(TX_FIRST))
    else $error("send word dropped");
  a_first_valid: assert property (TX_FIRST |-> TX_VALID)
    else $error("first flag without word");
endmodule
bind facq_sequencer facq_seq_monitor i_mon (.MCLK(MCLK), .ARST_N(ARST_N),
  .EXT_FRAME_TRIGGER(EXT_FRAME_TRIGGER), .EXPOSURE_CYC(EXPOSURE_CYC),
  .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
  .TX_FIRST(TX_FIRST), .EXPOSING(EXPOSING), .READING(READING),
  .TRIGGER_WAIT(TRIGGER_WAIT), .OVERTRIGGER(OVERTRIGGER));
`default_nettype wire

/* bench/facq_far_model.sv */
// Sensor source and host sink model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module facq_far_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        reading,
  input  wire logic        exposing,
  input  wire logic        stall,
  input  wire logic [15:0] words,
  output logic             sensor_valid,
  output logic [15:0]      sensor_data,
  output logic             tx_ready,
  output logic [15:0]      sent
);
  logic [15:0] nsent;
  // ==========================================
  // Idle data toggles so a stale word never looks valid by accident
  always @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sent <= 16'h0;
      sensor_valid <= 1'b0;
      sensor_data <= 16'h0;
      tx_ready <= 1'b0;
    end else begin
      nsent = exposing ? 16'h0 : sent + {15'h0, sensor_valid};
      sent <= nsent;
      sensor_valid <= reading && (nsent < words);
      sensor_data <= (reading && nsent < words) ? nsent ^ 16'hc3c3 : ~sensor_data;
      tx_ready <= stall ? ~tx_ready : 1'b1; // Slow host takes every other cycle
    end
  end
endmodule
`default_nettype wire

/* bench/tb_frame_acquisition_sequencer.sv */
// Self-checking bench for the frame acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module tb_frame_acquisition_sequencer;
  typedef struct {
    facq_pkg::facq_delay_mode_t m;
    logic ov; logic [23:0] ex; logic [23:0] xd; logic [15:0] w;
    logic slow; logic ot; int d;
  } facq_row_t;
  // Expected delays in cycles of 8 ns, extra delay already added
  facq_row_t rows [6] = '{
    '{facq_pkg::FACQ_GS_A, 0, 10, 0, 20, 0, 0, 2203},
    '{facq_pkg::FACQ_GS_B, 0, 12, 5, 200, 1, 1, 2690},
    '{facq_pkg::FACQ_OVERLAP, 0, 40, 0, 1, 0, 0, 25},
    '{facq_pkg::FACQ_OVERLAP, 1, 40, 3, 150, 0, 1, 68},
    '{facq_pkg::FACQ_OVERLAP, 1, 5000, 0, 130, 1, 0, 2150},
    '{facq_pkg::FACQ_ROLLING, 0, 64, 0, 10, 0, 0, 23751}};
  logic mclk, arst_n, trig, ov, slow, s_valid, tx_ready, tx_valid, tx_first;
  logic exposing, reading, trig_wait, overtrig, seen_tx, seen_rd;
  facq_pkg::facq_delay_mode_t mode;
  logic [23:0] expo, xd, tx_delay;
  logic [15:0] words, s_data, tx_data, rd_time, sent, rx_cnt;
  int n_errors, cmp_count, rd_cyc, tsd_cnt;
  facq_sequencer i_dut (.MCLK(mclk), .ARST_N(arst_n),
    .EXT_FRAME_TRIGGER(trig), .DELAY_MODE(mode), .OVERLAP_EN(ov),
    .EXPOSURE_CYC(expo), .EXTRA_DELAY_CYC(xd), .FRAME_WORDS(words),
    .SENSOR_VALID(s_valid), .SENSOR_DATA(s_data), .TX_READY(tx_ready),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_FIRST(tx_first),
    .EXPOSING(exposing), .READING(reading), .TRIGGER_WAIT(trig_wait),
    .OVERTRIGGER(overtrig), .READOUT_TIME_US(rd_time),
    .TX_START_DELAY(tx_delay));
  facq_far_model i_far (.clk(mclk), .arst_n(arst_n), .reading(reading),
    .exposing(exposing), .stall(slow), .words(words), .sensor_valid(s_valid),
    .sensor_data(s_data), .tx_ready(tx_ready), .sent(sent));
  // ==========================================
  // Clock and host-side watcher, sampled once outputs have settled
  always #4 mclk = ~mclk;
  always @(negedge mclk) begin
    #1;
    if (reading) begin
      rd_cyc++;
      seen_rd = 1'b1;
    end
    if (reading) `CHK(rx_cnt < words, 1'b1) // Send lags readout
    // Cycles from the rise of READING up to the rise of TX_VALID
    if (seen_rd && !tx_valid && !seen_tx) tsd_cnt++;
    if (tx_valid && !seen_tx) begin
      seen_tx = 1'b1;
      `CHK(sent >= ((words < 16'd128) ? words : 16'd128), 1'b1)
      `CHK(tx_delay, 24'(tsd_cnt)) // Readout to first word
    end
    if (tx_valid && tx_ready) begin
      `CHK(tx_data, rx_cnt ^ 16'hc3c3) // Word order
      `CHK(tx_first, rx_cnt == 16'h0) // First flag
      rx_cnt++;
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_lvl(input logic lvl);
    int k;
    k = 0;
    while (trig_wait !== lvl && k < 40000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 40000) begin
      n_errors++;
      $display("[ERR] t=%0t wait timeout", $time);
      end_of_test();
    end
  endtask
  // One triggered frame: delay, optional extra edge, words and readout time
  task automatic frame(input facq_row_t r);
    int n;
    wait_lvl(1'b1);
    @(negedge mclk);
    mode = r.m; ov = r.ov; expo = r.ex; xd = r.xd; words = r.w; slow = r.slow;
    rx_cnt = 16'h0; rd_cyc = 0; seen_tx = 1'b0;
    seen_rd = 1'b0; tsd_cnt = 0;
    trig = 1'b1; // Edge only while waiting
    @(posedge mclk);
    @(posedge mclk);
    #1 `CHK(trig_wait, 1'b0)
    // Rising edges counted since the trigger was driven
    n = 2;
    while (!exposing && n < 30000) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK(n, r.d + 1) // Start delay
    @(negedge mclk) trig = 1'b0;
    if (r.ot) begin
      @(negedge mclk) trig = 1'b1;
      @(posedge mclk);
      #1 `CHK(overtrig, 1'b1)
      `CHK(trig_wait, 1'b0) // Edge ignored
      @(posedge mclk);
      #1 `CHK(overtrig, 1'b0) // One-cycle pulse
      @(negedge mclk) trig = 1'b0;
    end
    wait_lvl(1'b1);
    `CHK(rx_cnt, r.w) // Whole frame sent
    `CHK(rd_time, 16'((rd_cyc * 8 + 999) / 1000))
    $display("frame test mode %0d words %0d done", r.m, r.w);
  endtask
  // ==========================================
  // Table of frames, then reset in mid-exposure
  initial begin
    mclk = 0; arst_n = 0; trig = 0; mode = facq_pkg::FACQ_GS_A; ov = 0;
    expo = 24'h1; xd = 24'h0; words = 16'h1; slow = 0; n_errors = 0;
    cmp_count = 0; rx_cnt = 16'h0; rd_cyc = 0; seen_tx = 0;
    seen_rd = 0; tsd_cnt = 0;
    repeat (2) @(negedge mclk);
    arst_n = 1;
    @(posedge mclk);
    #1 `CHK(trig_wait, 1'b1)
    foreach (rows[i]) frame(rows[i]);
    wait_lvl(1'b1);
    @(negedge mclk);
    mode = facq_pkg::FACQ_GS_A; expo = 24'h40; xd = 24'h0; trig = 1'b1;
    repeat (2230) @(negedge mclk);
    `CHK(exposing, 1'b1) // Delay of 2203 elapsed
    arst_n = 0;
    trig = 1'b0;
    #1 `CHK({exposing, trig_wait, tx_valid, overtrig}, 4'h0)
    repeat (2) @(negedge mclk);
    arst_n = 1;
    @(posedge mclk);
    #1 `CHK(trig_wait, 1'b1)
    $display("reset test done");
    frame(rows[0]);
    end_of_test();
  end
endmodule
`default_nettype wire
